//--- src/tmr_pkg.sv
// Constants, field layout and carrier types for the first-preset threshold map bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
// Behaviour
// - Twelfth delta-time field is bits 3:0, codes map 100 us up to 8000 us.
// - All map fields are read/write; contents are meaningless until software writes them.
// - Register 65h bits 7:3 hold the whole first level.
// - Register 65h bits 2:0 hold second level bits 4:2.
// - Register 66h bits 7:6 hold second level bits 1:0.
// - Register 66h bits 5:1 hold the whole third level.
// - Register 66h bit 0 holds fourth level bit 4.
// - Register 67h bits 7:4 hold fourth level bits 3:0.
// - Register 67h bits 3:0 hold fifth level bits 4:1.
// - Register 68h bit 7 holds fifth level bit 0.
// - Register 68h bits 6:2 hold the whole sixth level.
// - Register 68h bits 1:0 hold seventh level bits 4:3.
// - Register 69h bits 7:5 hold seventh level bits 2:0.
// - Register 69h bits 4:0 hold the whole eighth level.
// - Register 6Ah holds the full eight-bit ninth level.
// - First time point is absolute; later time fields are deltas from the previous.
package tmr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] TMR_IDX_TIMES_LAST = 8'h64;
	localparam logic [7:0] TMR_IDX_LEVELS_A   = 8'h65;
	localparam logic [7:0] TMR_IDX_LEVELS_B   = 8'h66;
	localparam logic [7:0] TMR_IDX_LEVELS_C   = 8'h67;
	localparam logic [7:0] TMR_IDX_LEVELS_D   = 8'h68;
	localparam logic [7:0] TMR_IDX_LEVELS_E   = 8'h69;
	localparam logic [7:0] TMR_IDX_LEVEL_NINE = 8'h6a;
	localparam logic [7:0] TMR_IDX_LEVEL_TEN  = 8'h6b;
	localparam int         TMR_NREG           = 8;

	// Storage slot of each register
	localparam logic [2:0] TMR_S_TIMES_LAST = 3'h0;
	localparam logic [2:0] TMR_S_LEVELS_A   = 3'h1;
	localparam logic [2:0] TMR_S_LEVELS_B   = 3'h2;
	localparam logic [2:0] TMR_S_LEVELS_C   = 3'h3;
	localparam logic [2:0] TMR_S_LEVELS_D   = 3'h4;
	localparam logic [2:0] TMR_S_LEVELS_E   = 3'h5;
	localparam logic [2:0] TMR_S_LEVEL_NINE = 3'h6;
	localparam logic [2:0] TMR_S_LEVEL_TEN  = 3'h7;

	// Field positions inside the storage bytes; split levels carry their high part first
	localparam int         TMR_L1_LSB    = 3;
	localparam int         TMR_L2_HI_LSB = 0;
	localparam int         TMR_L2_LO_LSB = 6;
	localparam int         TMR_L3_LSB    = 1;
	localparam int         TMR_L4_HI_BIT = 0;
	localparam int         TMR_L4_LO_LSB = 4;
	localparam int         TMR_L5_HI_LSB = 0;
	localparam int         TMR_L5_LO_BIT = 7;
	localparam int         TMR_L6_LSB    = 2;
	localparam int         TMR_L7_HI_LSB = 0;
	localparam int         TMR_L7_LO_LSB = 5;
	localparam int         TMR_L8_LSB    = 0;
	localparam int         TMR_T12_LSB   = 0;
	localparam int         TMR_T11_LSB   = 4;

	// Power-up value; any value is legal since contents are undefined until written
	localparam logic [7:0] TMR_REG_RST = 8'h00;

	// Delta-time lookup in microseconds, code 0 first
	localparam int         TMR_US_W = 13;
	localparam logic [TMR_US_W-1:0] TMR_US_TABLE [16] = '{
		13'h0064, 13'h00c8, 13'h012c, 13'h0190, 13'h0258, 13'h0320, 13'h03e8, 13'h04b0,
		13'h0578, 13'h07d0, 13'h0960, 13'h0c80, 13'h0fa0, 13'h1450, 13'h1900, 13'h1f40};

	typedef logic [4:0] tmr_lvl5_t;

	typedef struct packed {
		tmr_lvl5_t  first_preset_level_one;
		tmr_lvl5_t  first_preset_level_two;
		tmr_lvl5_t  first_preset_level_three;
		tmr_lvl5_t  first_preset_level_four;
		tmr_lvl5_t  first_preset_level_five;
		tmr_lvl5_t  first_preset_level_six;
		tmr_lvl5_t  first_preset_level_seven;
		tmr_lvl5_t  first_preset_level_eight;
		logic [7:0] first_preset_level_nine;
		logic [7:0] first_preset_level_ten;
	} tmr_levels_t;

	typedef struct packed {
		logic [3:0]          first_preset_twelfth_delta_time;
		logic [TMR_US_W-1:0] twelfth_delta_us;
		logic [3:0]          eleventh_delta_time;
	} tmr_times_t;

endpackage

//--- src/tmr_regs.sv
// First-preset threshold map register bank with a classic Wishbone slave.
// Assumes a 32-bit Wishbone master on clk; one clock, no interrupts.
`timescale 1ns/1ps

module tmr_regs
	import tmr_pkg::*;
#(
	parameter int ADR_W = 10
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// Assembled map towards the comparator
	output tmr_levels_t           levels_q,
	output tmr_times_t            times_q
);

	logic [7:0] regs_q [TMR_NREG];
	logic       ack_q;
	logic [31:0] dat_q;
	logic       req;
	logic       hit;
	logic [2:0] slot;
	logic [7:0] idx;

	assign req = wb_cyc_i & wb_stb_i;
	assign idx = 8'(wb_adr_i[ADR_W-1:2]);

	// Address decode to a storage slot
	always_comb
	begin
		hit  = 1'b1;
		slot = TMR_S_TIMES_LAST;
		case (idx)
			TMR_IDX_TIMES_LAST: slot = TMR_S_TIMES_LAST;
			TMR_IDX_LEVELS_A:   slot = TMR_S_LEVELS_A;
			TMR_IDX_LEVELS_B:   slot = TMR_S_LEVELS_B;
			TMR_IDX_LEVELS_C:   slot = TMR_S_LEVELS_C;
			TMR_IDX_LEVELS_D:   slot = TMR_S_LEVELS_D;
			TMR_IDX_LEVELS_E:   slot = TMR_S_LEVELS_E;
			TMR_IDX_LEVEL_NINE: slot = TMR_S_LEVEL_NINE;
			TMR_IDX_LEVEL_TEN:  slot = TMR_S_LEVEL_TEN;
			default:            hit  = 1'b0;
		endcase
	end

	// One wait state, ack drops the cycle after it was given
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// Read data captured on the same edge that raises ack; unmapped reads return zero
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			dat_q <= 32'h0000_0000;
		else if (req & ~ack_q)
			dat_q <= hit ? {24'h00_0000, regs_q[slot]} : 32'h0000_0000;
	end

	// Storage; write lands on the edge the master sees ack, lane 0 only
	generate
		for (genvar i = 0; i < TMR_NREG; i++)
		begin : g_reg
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					regs_q[i] <= TMR_REG_RST;
				else if (req & ack_q & wb_we_i & wb_sel_i[0] & hit & (slot == 3'(i)))
					regs_q[i] <= wb_dat_i[7:0];
			end
		end
	endgenerate

	// Split fields are rebuilt each cycle from current storage, so no commit step
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			levels_q <= '0;
		else
		begin
			levels_q.first_preset_level_one   <= regs_q[TMR_S_LEVELS_A][TMR_L1_LSB +: 5];
			levels_q.first_preset_level_two   <= {regs_q[TMR_S_LEVELS_A][TMR_L2_HI_LSB +: 3],
				regs_q[TMR_S_LEVELS_B][TMR_L2_LO_LSB +: 2]};
			levels_q.first_preset_level_three <= regs_q[TMR_S_LEVELS_B][TMR_L3_LSB +: 5];
			levels_q.first_preset_level_four  <= {regs_q[TMR_S_LEVELS_B][TMR_L4_HI_BIT],
				regs_q[TMR_S_LEVELS_C][TMR_L4_LO_LSB +: 4]};
			levels_q.first_preset_level_five  <= {regs_q[TMR_S_LEVELS_C][TMR_L5_HI_LSB +: 4],
				regs_q[TMR_S_LEVELS_D][TMR_L5_LO_BIT]};
			levels_q.first_preset_level_six   <= regs_q[TMR_S_LEVELS_D][TMR_L6_LSB +: 5];
			levels_q.first_preset_level_seven <= {regs_q[TMR_S_LEVELS_D][TMR_L7_HI_LSB +: 2],
				regs_q[TMR_S_LEVELS_E][TMR_L7_LO_LSB +: 3]};
			levels_q.first_preset_level_eight <= regs_q[TMR_S_LEVELS_E][TMR_L8_LSB +: 5];
			levels_q.first_preset_level_nine  <= regs_q[TMR_S_LEVEL_NINE];
			levels_q.first_preset_level_ten   <= regs_q[TMR_S_LEVEL_TEN];
		end
	end

	// Times are deltas from the preceding point; summing is left to the consumer
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			times_q <= '0;
		else
		begin
			times_q.first_preset_twelfth_delta_time <=
				regs_q[TMR_S_TIMES_LAST][TMR_T12_LSB +: 4];
			times_q.twelfth_delta_us <=
				TMR_US_TABLE[regs_q[TMR_S_TIMES_LAST][TMR_T12_LSB +: 4]];
			times_q.eleventh_delta_time <= regs_q[TMR_S_TIMES_LAST][TMR_T11_LSB +: 4];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule

//--- sim/tmr_regs_properties.sv
// Port checker for the first-preset threshold map bank.
// Assumes it is bound to tmr_regs; one clock, async reset.
`timescale 1ns/1ps
module tmr_regs_chk
	import tmr_pkg::*;
#(
	parameter int ADR_W = 10
)(
	// Clock and reset
	input wire logic              clk,
	input wire logic              sys_rst,
	// Wishbone
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADR_W-1:0]  wb_adr_i,
	input wire logic [3:0]        wb_sel_i,
	input wire logic [31:0]       wb_dat_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	// Map
	input wire tmr_levels_t       levels_q,
	input wire tmr_times_t        times_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Write seen at its ack edge; outputs follow two edges later
	sequence wr_s(logic [7:0] i);
		wb_ack_o && wb_we_i && wb_sel_i[0] && 8'(wb_adr_i[ADR_W-1:2]) == i;
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack unasked");
	rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper bits");
	lvl_one_a: assert property (wr_s(8'h65) |-> ##2
		levels_q.first_preset_level_one == $past(wb_dat_i[7:3], 2)) else $error("level one");
	lvl_two_a: assert property (wr_s(8'h66) |-> ##2
		levels_q.first_preset_level_two[1:0] == $past(wb_dat_i[7:6], 2)) else $error("level two");
	lvl_eight_a: assert property (wr_s(8'h69) |-> ##2
		levels_q.first_preset_level_eight == $past(wb_dat_i[4:0], 2)) else $error("level eight");
	lvl_nine_a: assert property (wr_s(8'h6a) |-> ##2
		levels_q.first_preset_level_nine == $past(wb_dat_i[7:0], 2)) else $error("level nine");
	delta_code_a: assert property (wr_s(8'h64) |-> ##2
		times_q.first_preset_twelfth_delta_time == $past(wb_dat_i[3:0], 2)) else $error("delta");
	delta_prev_a: assert property (wr_s(8'h64) |-> ##2
		times_q.eleventh_delta_time == $past(wb_dat_i[7:4], 2)) else $error("prev delta");
endmodule

bind tmr_regs tmr_regs_chk #(.ADR_W(ADR_W)) chk (.clk(clk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.levels_q(levels_q), .times_q(times_q));

//--- sim/tmr_regs_tb_top.sv
// Self-checking bench for the threshold map bank over Wishbone.
// Assumes tmr_regs answers every request one cycle after taking it.
`timescale 1ns/1ps
module tmr_regs_tb_top import tmr_pkg::*;
;
	logic        clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [9:0]  adr = '0;
	logic [3:0]  sel = '0;
	logic [31:0] wdat = '0, rdat, q;
	tmr_levels_t lv;
	tmr_times_t  tm;
	int          miscompares = 0, n_compared = 0;
	int          us [16] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400, 2000, 2400,
		3200, 4000, 5200, 6400, 8000};
	logic [7:0]  pat [7] = '{8'ha5, 8'h6c, 8'h9e, 8'hd3, 8'h4b, 8'hc7, 8'h3e};
	always #50 clk = ~clk;
	tmr_regs uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.levels_q(lv), .times_q(tm));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled, then released for at least a cycle
	task automatic bus(input logic w, input logic s, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		{cyc, stb, we} <= {2'b11, w};
		sel <= {3'h0, s};
		adr <= {i, 2'h0};
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic finish_test;
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run is well under 2000 cycles
	initial
	begin
		#500000;
		miscompares++;
		finish_test;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 7; k++)
			bus(1'b1, 1'b1, 8'(k + 'h65), pat[k]);
		repeat (3) @(posedge clk);
		chk(lv, {5'h14, 5'h15, 5'h16, 5'h09, 5'h1d, 5'h14, 5'h1a, 5'h0b,
			8'hc7, 8'h3e});
		for (int k = 0; k < 7; k++)
		begin
			bus(1'b0, 1'b1, 8'(k + 'h65), 8'h00);
			chk(q, {24'h0, pat[k]});
		end
		// Lane 0 disabled must leave storage alone; an unmapped index must read back zero
		bus(1'b1, 1'b0, 8'h6a, 8'h11);
		bus(1'b0, 1'b1, 8'h6a, 8'h00);
		chk(q, 32'h0000_00c7);
		bus(1'b1, 1'b1, 8'h70, 8'hff);
		bus(1'b0, 1'b1, 8'h70, 8'h00);
		chk(q, 32'h0);
		for (int k = 0; k < 16; k++)
		begin
			bus(1'b1, 1'b1, 8'h64, {4'(15 - k), 4'(k)});
			repeat (3) @(posedge clk);
			chk(tm.twelfth_delta_us, us[k]);
			chk(tm.first_preset_twelfth_delta_time, k);
			chk(tm.eleventh_delta_time, 15 - k);
			bus(1'b0, 1'b1, 8'h64, 8'h00);
			chk(q, {24'h0, 4'(15 - k), 4'(k)});
		end
		finish_test;
	end
endmodule
